// ===== phy_mgmt_pkg.sv
// constants and carriers for the coding / medium-attachment management register bank
// Operation
// - pcs reset bit restores pcs defaults, self-clears
// - pcs loopback bit routes mac frames back
// - fault bit sets on local/remote jabber
// - fault latched, cleared by read, resets one
// - remote jabber counter, clear-on-read, saturates
// - physical collision counter, clear-on-read, saturates
// - plca logical collisions never counted
// - devices-in-package words: 0x000b and zero
// - extended ability reads only bit 3
// - pma reset starts soft reset, self-clears
// - transmit disable blocks mac transmit requests
// - multidrop bit reads one, low power zero
// - pma loopback shares storage with aliases
// - third map holds standard 16-bit words
// - upper two bytes read zero, ignore writes
`default_nettype none
package phy_mgmt_pkg;

  // memory map selectors
  localparam logic [3:0] MAP_PCS = 4'h2;
  localparam logic [3:0] MAP_PMA = 4'h3;

  // register offsets
  localparam logic [15:0] OFS_DEV_PKG_LO = 16'h0005;
  localparam logic [15:0] OFS_DEV_PKG_HI = 16'h0006;
  localparam logic [15:0] OFS_PCS_CTRL = 16'h08f3;
  localparam logic [15:0] OFS_PCS_STAT = 16'h08f4;
  localparam logic [15:0] OFS_RJ_CNT = 16'h08f5;
  localparam logic [15:0] OFS_COL_CNT = 16'h08f6;
  localparam logic [15:0] OFS_EXT_ABIL = 16'h0012;
  localparam logic [15:0] OFS_PMA_CTRL = 16'h08f9;

  // field positions
  localparam int PCS_RST_BIT = 15;
  localparam int PCS_LOOP_BIT = 14;
  localparam int FAULT_BIT = 7;
  localparam int PMA_RST_BIT = 15;
  localparam int TX_DIS_BIT = 14;
  localparam int LOW_PWR_BIT = 11;
  localparam int MULTIDROP_BIT = 10;
  localparam int PMA_LOOP_BIT = 0;

  // fixed read values and reset values
  localparam logic [15:0] DEV_PKG_LO_VAL = 16'h000b;
  localparam logic [15:0] DEV_PKG_HI_VAL = 16'h0000;
  localparam logic [15:0] EXT_ABIL_VAL = 16'h0008;
  localparam logic FAULT_RST = 1'b1;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;

  // one register access from the serial link decoder
  typedef struct packed {
    logic wr;
    logic [3:0] memory_map_select; // register map the access targets
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // coding sublayer event strobes
  typedef struct packed {
    logic local_jabber;
    logic remote_jabber;
    logic phys_collision;
  } pcs_events_t;

endpackage
`default_nettype wire

// ===== phy_pcs_pma_mgmt_regs.sv
// management register bank for the coding and medium-attachment sublayers
`timescale 1ns/1ps
`default_nettype none
module phy_pcs_pma_mgmt_regs (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire phy_mgmt_pkg::reg_req_t req,
  output logic ack,
  output logic [31:0] rdata,
  input wire phy_mgmt_pkg::pcs_events_t events,
  input wire logic station_management_loop_wr,
  input wire logic station_management_loop_val,
  input wire logic soft_reset_done,
  input wire logic mac_tx_req,
  output logic line_tx_req,
  output logic line_tx_enable,
  output logic pcs_loopback,
  output logic pma_loopback,
  output logic pcs_pma_reset,
  output logic soft_reset_req
);

  // state of the bank
  logic pcs_loop_reg; // coding loopback enable
  logic fault_reg; // latched jabber fault
  logic [15:0] rj_cnt_reg; // remote jabber count
  logic [15:0] col_cnt_reg; // physical collision count
  logic tx_dis_reg; // transmitter disable
  logic pma_loop_reg; // shared loopback storage
  logic pcs_rst_reg; // self-clearing pcs reset pulse
  logic soft_rst_reg; // soft reset in progress

  // decoded strobes of the current access
  logic rd_stb, wr_stb;
  logic wr_pcs_ctrl, wr_pma_ctrl;
  logic rd_stat, rd_rj, rd_col;
  logic defaults_now;
  logic [3:0] map_sel; // memory map select of the current access

  // true when an access hits the given map and offset
  function automatic logic hit(input logic [3:0] m, input logic [15:0] a,
                               input logic [3:0] mm, input logic [15:0] aa);
    hit = (m == mm) && (a == aa);
  endfunction

  // saturating counter step with clear-on-read; event beats the clear
  function automatic logic [15:0] cnt_step(input logic [15:0] c, input logic clr, input logic ev);
    logic [15:0] base;
    base = clr ? phy_mgmt_pkg::CNT_RST : c;
    if (ev && base != phy_mgmt_pkg::CNT_MAX) begin
      cnt_step = base + 16'h0001;
    end else begin
      cnt_step = base;
    end
  endfunction

  // strobe decode
  assign rd_stb = req_valid && !req.wr;
  assign wr_stb = req_valid && req.wr;
  assign map_sel = req.memory_map_select;
  assign wr_pcs_ctrl = wr_stb && hit(map_sel, req.addr, phy_mgmt_pkg::MAP_PCS, phy_mgmt_pkg::OFS_PCS_CTRL);
  assign wr_pma_ctrl = wr_stb && hit(map_sel, req.addr, phy_mgmt_pkg::MAP_PMA, phy_mgmt_pkg::OFS_PMA_CTRL);
  assign rd_stat = rd_stb && hit(map_sel, req.addr, phy_mgmt_pkg::MAP_PCS, phy_mgmt_pkg::OFS_PCS_STAT);
  assign rd_rj = rd_stb && hit(map_sel, req.addr, phy_mgmt_pkg::MAP_PCS, phy_mgmt_pkg::OFS_RJ_CNT);
  assign rd_col = rd_stb && hit(map_sel, req.addr, phy_mgmt_pkg::MAP_PCS, phy_mgmt_pkg::OFS_COL_CNT);
  // pcs registers go to defaults on device reset, pcs reset write, or end of soft reset
  assign defaults_now = wr_pcs_ctrl && req.wdata[phy_mgmt_pkg::PCS_RST_BIT];

  // pcs reset pulse: one cycle, then clears by itself
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pcs_rst_reg <= 1'b0;
    end else begin
      pcs_rst_reg <= defaults_now;
    end
  end

  // coding loopback control
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pcs_loop_reg <= 1'b0;
    end else if (defaults_now || (soft_rst_reg && soft_reset_done)) begin
      pcs_loop_reg <= 1'b0;
    end else if (wr_pcs_ctrl) begin
      pcs_loop_reg <= req.wdata[phy_mgmt_pkg::PCS_LOOP_BIT];
    end
  end

  // jabber fault latch; a new jabber wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fault_reg <= phy_mgmt_pkg::FAULT_RST;
    end else if (defaults_now || (soft_rst_reg && soft_reset_done)) begin
      fault_reg <= phy_mgmt_pkg::FAULT_RST;
    end else if (events.local_jabber || events.remote_jabber) begin
      fault_reg <= 1'b1;
    end else if (rd_stat) begin
      fault_reg <= 1'b0;
    end
  end

  // remote jabber counter
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rj_cnt_reg <= phy_mgmt_pkg::CNT_RST;
    end else if (defaults_now || (soft_rst_reg && soft_reset_done)) begin
      rj_cnt_reg <= phy_mgmt_pkg::CNT_RST;
    end else begin
      rj_cnt_reg <= cnt_step(rj_cnt_reg, rd_rj, events.remote_jabber);
    end
  end

  // physical collision counter; only the line-level collision strobe feeds it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      col_cnt_reg <= phy_mgmt_pkg::CNT_RST;
    end else if (defaults_now || (soft_rst_reg && soft_reset_done)) begin
      col_cnt_reg <= phy_mgmt_pkg::CNT_RST;
    end else begin
      col_cnt_reg <= cnt_step(col_cnt_reg, rd_col, events.phys_collision);
    end
  end

  // soft reset request: set by write, held until the device reports completion
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      soft_rst_reg <= 1'b0;
    end else if (soft_rst_reg && soft_reset_done) begin
      soft_rst_reg <= 1'b0;
    end else if (wr_pma_ctrl && req.wdata[phy_mgmt_pkg::PMA_RST_BIT]) begin
      soft_rst_reg <= 1'b1;
    end
  end

  // transmitter disable control
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_dis_reg <= 1'b0;
    end else if (soft_rst_reg && soft_reset_done) begin
      tx_dis_reg <= 1'b0;
    end else if (wr_pma_ctrl) begin
      tx_dis_reg <= req.wdata[phy_mgmt_pkg::TX_DIS_BIT];
    end
  end

  // shared loopback storage; register write wins over an alias write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pma_loop_reg <= 1'b0;
    end else if (soft_rst_reg && soft_reset_done) begin
      pma_loop_reg <= 1'b0;
    end else if (wr_pma_ctrl) begin
      pma_loop_reg <= req.wdata[phy_mgmt_pkg::PMA_LOOP_BIT];
    end else if (station_management_loop_wr) begin
      pma_loop_reg <= station_management_loop_val;
    end
  end

  // read mux: every word is 16 bits, upper half always zero
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000; // unmapped reads zero
    if (map_sel == phy_mgmt_pkg::MAP_PCS) begin
      unique case (req.addr)
        phy_mgmt_pkg::OFS_DEV_PKG_LO: rd_word = phy_mgmt_pkg::DEV_PKG_LO_VAL;
        phy_mgmt_pkg::OFS_DEV_PKG_HI: rd_word = phy_mgmt_pkg::DEV_PKG_HI_VAL;
        phy_mgmt_pkg::OFS_PCS_CTRL: rd_word[phy_mgmt_pkg::PCS_LOOP_BIT] = pcs_loop_reg;
        phy_mgmt_pkg::OFS_PCS_STAT: rd_word[phy_mgmt_pkg::FAULT_BIT] = fault_reg;
        phy_mgmt_pkg::OFS_RJ_CNT: rd_word = rj_cnt_reg;
        phy_mgmt_pkg::OFS_COL_CNT: rd_word = col_cnt_reg;
        default: rd_word = 16'h0000;
      endcase
    end else if (map_sel == phy_mgmt_pkg::MAP_PMA) begin
      unique case (req.addr)
        phy_mgmt_pkg::OFS_DEV_PKG_LO: rd_word = phy_mgmt_pkg::DEV_PKG_LO_VAL;
        phy_mgmt_pkg::OFS_DEV_PKG_HI: rd_word = phy_mgmt_pkg::DEV_PKG_HI_VAL;
        phy_mgmt_pkg::OFS_EXT_ABIL: rd_word = phy_mgmt_pkg::EXT_ABIL_VAL;
        phy_mgmt_pkg::OFS_PMA_CTRL: begin
          rd_word[phy_mgmt_pkg::PMA_RST_BIT] = soft_rst_reg;
          rd_word[phy_mgmt_pkg::TX_DIS_BIT] = tx_dis_reg;
          rd_word[phy_mgmt_pkg::LOW_PWR_BIT] = 1'b0;
          rd_word[phy_mgmt_pkg::MULTIDROP_BIT] = 1'b1;
          rd_word[phy_mgmt_pkg::PMA_LOOP_BIT] = pma_loop_reg;
        end
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // answer one cycle after each access, with the value before side effects
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= req_valid;
      rdata <= rd_stb ? {phy_mgmt_pkg::UPPER_ZERO, rd_word} : 32'h0000_0000;
    end
  end

  // transmit path gate toward the line driver
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      line_tx_req <= 1'b0;
      line_tx_enable <= 1'b1;
    end else begin
      line_tx_req <= mac_tx_req && !tx_dis_reg;
      line_tx_enable <= !tx_dis_reg;
    end
  end

  // control outputs straight from the state flops
  assign pcs_loopback = pcs_loop_reg;
  assign pma_loopback = pma_loop_reg;
  assign pcs_pma_reset = pcs_rst_reg;
  assign soft_reset_req = soft_rst_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_pcs_rst_write;
    wr_pcs_ctrl && req.wdata[phy_mgmt_pkg::PCS_RST_BIT];
  endsequence

  // a second reset write right behind the first keeps the pulse up
  sequence s_rst_pulse;
    pcs_pma_reset && !pcs_loopback && fault_reg ##1 (!pcs_pma_reset || $past(defaults_now));
  endsequence

  AST_PCS_RST: assert property (s_pcs_rst_write |=> s_rst_pulse)
    else $error("pcs reset did not restore defaults and self-clear");

  AST_LOOP_WR: assert property (wr_pcs_ctrl && !req.wdata[phy_mgmt_pkg::PCS_RST_BIT]
      && !(soft_rst_reg && soft_reset_done) |=> pcs_loopback == $past(req.wdata[phy_mgmt_pkg::PCS_LOOP_BIT]))
    else $error("pcs loopback did not take written value");

  AST_FAULT_SET: assert property (events.local_jabber || events.remote_jabber |=> fault_reg)
    else $error("jabber did not set fault");

  AST_FAULT_HOLD: assert property (fault_reg && !rd_stat |=> fault_reg)
    else $error("fault cleared without a read");

  AST_RJ_SAT: assert property (rj_cnt_reg == phy_mgmt_pkg::CNT_MAX && !rd_rj && !defaults_now
      && !(soft_rst_reg && soft_reset_done) |=> rj_cnt_reg == phy_mgmt_pkg::CNT_MAX)
    else $error("remote jabber count wrapped");

  AST_COL_READ: assert property (rd_col && !defaults_now && !(soft_rst_reg && soft_reset_done)
      |=> col_cnt_reg == {15'h0000, $past(events.phys_collision)})
    else $error("collision count not cleared by read");

  AST_DIP_READ: assert property (rd_stb && req.addr == phy_mgmt_pkg::OFS_DEV_PKG_LO
      && (map_sel == phy_mgmt_pkg::MAP_PCS || map_sel == phy_mgmt_pkg::MAP_PMA)
      |=> ack && rdata == 32'h0000_000b)
    else $error("devices-in-package word wrong");

  AST_EXT_ABIL: assert property (rd_stb && hit(map_sel, req.addr,
      phy_mgmt_pkg::MAP_PMA, phy_mgmt_pkg::OFS_EXT_ABIL) |=> rdata == 32'h0000_0008)
    else $error("extended ability word wrong");

  AST_SOFT_RST: assert property (soft_reset_req && !soft_reset_done |=> soft_reset_req)
    else $error("soft reset bit cleared before completion");

  AST_TX_GATE: assert property (tx_dis_reg |=> !line_tx_req && !line_tx_enable)
    else $error("transmit request passed while disabled");

  AST_PMA_CTRL: assert property (rd_stb && hit(map_sel, req.addr,
      phy_mgmt_pkg::MAP_PMA, phy_mgmt_pkg::OFS_PMA_CTRL) |=> rdata[10] && !rdata[11] && rdata[31:16] == 16'h0000)
    else $error("medium_attachment_control fixed bits wrong");

  AST_ALIAS: assert property (station_management_loop_wr && !wr_pma_ctrl && !(soft_rst_reg && soft_reset_done)
      |=> pma_loopback == $past(station_management_loop_val))
    else $error("alias write did not reach shared loopback");

  AST_FAULT_CLR: assert property (rd_stat && !events.local_jabber && !events.remote_jabber
      && !(soft_rst_reg && soft_reset_done) |=> !fault_reg)
    else $error("fault not cleared by a status read");

  AST_RJ_READ: assert property (rd_rj && !defaults_now && !(soft_rst_reg && soft_reset_done)
      |=> rj_cnt_reg == {15'h0000, $past(events.remote_jabber)})
    else $error("remote jabber count not cleared by read");

  AST_COL_SAT: assert property (col_cnt_reg == phy_mgmt_pkg::CNT_MAX && !rd_col && !defaults_now
      && !(soft_rst_reg && soft_reset_done) |=> col_cnt_reg == phy_mgmt_pkg::CNT_MAX)
    else $error("collision count wrapped");

  AST_COL_STEP: assert property (events.phys_collision && !rd_col && col_cnt_reg != phy_mgmt_pkg::CNT_MAX
      && !defaults_now && !(soft_rst_reg && soft_reset_done) |=> col_cnt_reg == $past(col_cnt_reg) + 16'h0001)
    else $error("physical collision not counted");

  AST_COL_ONLY_PHYS: assert property (!events.phys_collision && !rd_col && !defaults_now
      && !(soft_rst_reg && soft_reset_done) |=> $stable(col_cnt_reg))
    else $error("collision count moved without a physical collision");

  AST_WR_ANSWER: assert property (wr_stb |=> ack && rdata == 32'h0000_0000)
    else $error("write answered with data or without ack");

  AST_UPPER_ZERO: assert property (ack |-> rdata[31:16] == phy_mgmt_pkg::UPPER_ZERO)
    else $error("upper half of a read word not zero");

  AST_PCS_CTRL_RD: assert property (rd_stb && hit(map_sel, req.addr,
      phy_mgmt_pkg::MAP_PCS, phy_mgmt_pkg::OFS_PCS_CTRL) |=> !rdata[15] && rdata[13:0] == 14'h0000)
    else $error("coding_sublayer_control fixed bits not zero");

  // completion of a soft reset seen by the bank
  sequence s_soft_done;
    soft_reset_req && soft_reset_done;
  endsequence

  AST_SOFT_DEFAULTS: assert property (s_soft_done
      |=> !soft_reset_req && fault_reg && !pcs_loopback && !pma_loopback)
    else $error("soft reset completion did not restore defaults");

endmodule
`default_nettype wire

// ===== reg_host_model.sv
// host model that issues single-cycle register accesses over the serial link decoder port
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  input wire logic ref_clk,
  output var logic req_valid,
  output var phy_mgmt_pkg::reg_req_t req
);
  // idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // one access: fields change after an edge and are held up to the taking edge
  task automatic access(input logic wr, input logic [3:0] sel, input logic [15:0] addr, input logic [31:0] wdata);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= {wr, sel, addr, wdata};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    // released fields carry inverted garbage, never the old value
    req <= ~{wr, sel, addr, wdata};
  endtask
endmodule
`default_nettype wire

// ===== phy_pcs_pma_mgmt_regs_tb.sv
// self-checking bench for the management register bank
`timescale 1ns/1ps
`default_nettype none
module phy_pcs_pma_mgmt_regs_tb;
  logic ref_clk, nrst, req_valid, ack, soft_reset_done, mac_tx_req, line_tx_req, line_tx_enable;
  logic station_management_loop_wr, station_management_loop_val, pcs_loopback, pma_loopback;
  logic pcs_pma_reset, soft_reset_req;
  phy_mgmt_pkg::reg_req_t req; // access fields from the host model
  phy_mgmt_pkg::pcs_events_t events; // event strobes
  logic [31:0] rdata; // read word
  logic [31:0] exp_q[$]; // expected words, oldest first
  logic [31:0] lfsr; // random source
  int err_total, checked, cycles;
  // fixed words: map, offset, value; last three are unmapped places
  logic [35:0] fixed_words [10] = '{{4'h2, 16'h0005, 16'h000b}, {4'h2, 16'h0006, 16'h0000},
    {4'h3, 16'h0005, 16'h000b}, {4'h3, 16'h0006, 16'h0000}, {4'h3, 16'h0012, 16'h0008},
    {4'h2, 16'h08f5, 16'h0000}, {4'h2, 16'h08f6, 16'h0000}, {4'h5, 16'h0005, 16'h0000},
    {4'h2, 16'h0012, 16'h0000}, {4'h3, 16'h08fa, 16'h0000}};

  // clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  reg_host_model host (.ref_clk(ref_clk), .req_valid(req_valid), .req(req));

  phy_pcs_pma_mgmt_regs DUT (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req(req), .ack(ack),
    .rdata(rdata), .events(events), .station_management_loop_wr(station_management_loop_wr),
    .station_management_loop_val(station_management_loop_val), .soft_reset_done(soft_reset_done),
    .mac_tx_req(mac_tx_req), .line_tx_req(line_tx_req), .line_tx_enable(line_tx_enable),
    .pcs_loopback(pcs_loopback), .pma_loopback(pma_loopback), .pcs_pma_reset(pcs_pma_reset),
    .soft_reset_req(soft_reset_req));

  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // next random word
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // note the expected answer, then let the host issue the access
  task automatic acc(input logic wr, input logic [3:0] sel, input logic [15:0] addr, input logic [31:0] d);
    exp_q.push_back(wr ? 32'h0 : d);
    host.access(wr, sel, addr, wr ? d : 32'h0);
  endtask

  // hold an event pattern high for n sampling edges
  task automatic ev(input logic [2:0] e, input int n);
    @(posedge ref_clk);
    events <= e;
    repeat (n) @(posedge ref_clk);
    events <= '0;
  endtask

  // scoreboard: each ack takes the oldest note; cycle ceiling
  always @(posedge ref_clk) begin
    cycles++;
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spare ack", 32'h1, 32'h0);
      end else begin
        chk("rdata", rdata, exp_q.pop_front());
      end
    end
    if (cycles > 80000) begin
      err_total++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    mac_tx_req = 1'b0;
    soft_reset_done = 1'b0;
    station_management_loop_wr = 1'b0;
    station_management_loop_val = 1'b0;
    events = '0;
    lfsr = 32'h7245;
    err_total = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    // fault reads one after reset, then clears on read
    acc(1'b0, 4'h2, 16'h08f4, 32'h0080);
    acc(1'b0, 4'h2, 16'h08f4, 32'h0000);
    // fixed words ignore random writes, upper half reads zero
    for (int i = 0; i < 10; i++) begin
      lfsr = nxt(lfsr);
      acc(1'b1, fixed_words[i][35:32], fixed_words[i][31:16], lfsr);
      acc(1'b0, fixed_words[i][35:32], fixed_words[i][31:16], {16'h0, fixed_words[i][15:0]});
    end
    // counters and fault flag
    ev(3'b010, 3);
    acc(1'b0, 4'h2, 16'h08f5, 32'h0003);
    acc(1'b0, 4'h2, 16'h08f4, 32'h0080);
    acc(1'b0, 4'h2, 16'h08f5, 32'h0000);
    acc(1'b0, 4'h2, 16'h08f4, 32'h0000);
    ev(3'b001, 2);
    acc(1'b0, 4'h2, 16'h08f6, 32'h0002);
    ev(3'b100, 1);
    acc(1'b0, 4'h2, 16'h08f4, 32'h0080);
    ev(3'b011, 65537);
    acc(1'b0, 4'h2, 16'h08f6, 32'h0000ffff);
    acc(1'b0, 4'h2, 16'h08f5, 32'h0000ffff);
    // coding loopback, then coding reset restores defaults
    ev(3'b011, 2);
    lfsr = nxt(lfsr);
    acc(1'b1, 4'h2, 16'h08f3, {lfsr[31:16], 16'h4000});
    @(negedge ref_clk);
    chk("pcs_loopback", pcs_loopback, 32'h1);
    acc(1'b0, 4'h2, 16'h08f3, 32'h4000);
    acc(1'b1, 4'h2, 16'h08f3, 32'h8000);
    @(negedge ref_clk);
    chk("pcs_pma_reset", pcs_pma_reset, 32'h1);
    @(negedge ref_clk);
    chk("pcs_pma_reset", pcs_pma_reset, 32'h0);
    chk("pcs_loopback", pcs_loopback, 32'h0);
    acc(1'b0, 4'h2, 16'h08f3, 32'h0000);
    acc(1'b0, 4'h2, 16'h08f5, 32'h0000);
    acc(1'b0, 4'h2, 16'h08f4, 32'h0080);
    // transmit disable, fixed bits and shared loopback
    lfsr = nxt(lfsr);
    acc(1'b1, 4'h3, 16'h08f9, {lfsr[31:16], 16'h4801});
    mac_tx_req <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("line_tx_enable", line_tx_enable, 32'h0);
    chk("line_tx_req", line_tx_req, 32'h0);
    chk("pma_loopback", pma_loopback, 32'h1);
    acc(1'b0, 4'h3, 16'h08f9, 32'h4401);
    // alias writes of zero, then one, show in the shared bit
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      station_management_loop_wr <= 1'b1;
      station_management_loop_val <= v[0];
      @(posedge ref_clk);
      station_management_loop_wr <= 1'b0;
      acc(1'b0, 4'h3, 16'h08f9, {16'h0000, 15'h2200, v[0]});
    end
    acc(1'b1, 4'h3, 16'h08f9, 32'h0000);
    repeat (2) @(negedge ref_clk);
    chk("line_tx_enable", line_tx_enable, 32'h1);
    chk("line_tx_req", line_tx_req, 32'h1);
    // soft reset holds until the device reports it done
    acc(1'b1, 4'h3, 16'h08f9, 32'h8000);
    acc(1'b0, 4'h3, 16'h08f9, 32'h8400);
    @(negedge ref_clk);
    chk("soft_reset_req", soft_reset_req, 32'h1);
    @(posedge ref_clk);
    soft_reset_done <= 1'b1;
    @(posedge ref_clk);
    soft_reset_done <= 1'b0;
    @(negedge ref_clk);
    chk("soft_reset_req", soft_reset_req, 32'h0);
    acc(1'b0, 4'h3, 16'h08f9, 32'h0400);
    acc(1'b0, 4'h2, 16'h08f4, 32'h0080);
    repeat (3) @(posedge ref_clk);
    chk("pending answers", exp_q.size(), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
